/* shared/crc_sequence_function_consts.vh */
/*
  Constants for the CRC / pseudo-random sequence block: register offsets,
  control field positions, status bit positions and reset values.
  Assumes the includer is a design file or the bench of that block.
*/
// What this block does
// - Disabled seed write also loads shift state
// - Enabled block outside pass mode shifts CRC each rising block clock edge
// - Zero data input yields pseudo-random sequence
// - Selected MSB drives primary output
// - Default compare is state equals seed
// - Equality compare holds high while state equals seed
// - Mode bits select less-or-equal or less-than
// - Compare drives auxiliary output and interrupt
// - Pass mode routes data, rising edge interrupts
// - Pass mode routes clock input to auxiliary
// - Lowest stage takes MSB XOR data
// - Galois taps XOR MSB XOR data into bits
// - Priority decode picks single MSB driver
// - Unity term implied, not stored
// - Polynomial bit 0 is tap 1
// - Chained block takes previous shift output
// - All-zero state with zero data sticks
`ifndef CRC_SEQUENCE_FUNCTION_CONSTS_VH
`define CRC_SEQUENCE_FUNCTION_CONSTS_VH

`define CRC_SEQUENCE_FUNCTION_WIDTH 8
`define CRC_SEQUENCE_FUNCTION_ADDR_W 12

`define CRC_SEQUENCE_FUNCTION_OFF_SHIFT 12'h000
`define CRC_SEQUENCE_FUNCTION_OFF_POLY 12'h004
`define CRC_SEQUENCE_FUNCTION_OFF_SEED 12'h008
`define CRC_SEQUENCE_FUNCTION_OFF_CTRL 12'h00c
`define CRC_SEQUENCE_FUNCTION_OFF_STATUS 12'h010

`define CRC_SEQUENCE_FUNCTION_CTRL_ENABLE 0
`define CRC_SEQUENCE_FUNCTION_CTRL_PASS 1
`define CRC_SEQUENCE_FUNCTION_CTRL_MODE0 2
`define CRC_SEQUENCE_FUNCTION_CTRL_MODE1 3
`define CRC_SEQUENCE_FUNCTION_CTRL_CHAIN 4
`define CRC_SEQUENCE_FUNCTION_CTRL_W 5

`define CRC_SEQUENCE_FUNCTION_ST_CMP 0
`define CRC_SEQUENCE_FUNCTION_ST_IRQ 1
`define CRC_SEQUENCE_FUNCTION_ST_PRIM 2
`define CRC_SEQUENCE_FUNCTION_ST_AUX 3

`define CRC_SEQUENCE_FUNCTION_RST_BYTE 8'h00
`define CRC_SEQUENCE_FUNCTION_RST_CTRL 5'h00
`define CRC_SEQUENCE_FUNCTION_ZERO32 32'h00000000

`endif

/* src/crc_sequence_function_lfsr_stage.v */
/*
  One 8-bit modular shift stage with polynomial taps and its MSB driver
  select. Assumes a caller that holds the registers and steps it.
*/
`timescale 1ns/1ns
`include "crc_sequence_function_consts.vh"

module crc_sequence_function_lfsr_stage (
  input wire [7:0] state_in,
  input wire [7:0] poly_in,
  input wire data_in,
  output wire [7:0] next_out,
  output reg [7:0] msb_sel_out,
  output wire msb_out
);
  integer i;
  reg found;
  wire feedback_bus;

  always @* begin
    msb_sel_out = 8'h00;
    found = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (poly_in[i] && !found) begin
        msb_sel_out[i] = 1'b1;
        found = 1'b1;
      end
    end
  end

  assign msb_out = |(state_in & msb_sel_out);
  assign feedback_bus = msb_out ^ data_in;
  // Galois tap XOR; bit 0 is tap 1
  // Feedback enters bit 0 (implied unity term); tap k sits at poly bit k-1
  assign next_out = {state_in[6:0], feedback_bus} ^ ({poly_in[6:0], 1'b0} & {8{feedback_bus}});

endmodule // crc_sequence_function_lfsr_stage

/* src/crc_sequence_function_block.v */
/*
  CRC / pseudo-random sequence block with APB register access, compare,
  pass mode and chaining. Assumes data and clock inputs come from pins or
  another domain and are synchronised here; APB is on clock_in.
*/
`timescale 1ns/1ns
`include "crc_sequence_function_consts.vh"

module crc_sequence_function_block (
  input wire clock_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire data_in,
  input wire blk_clk_in,
  input wire chain_din_in,
  output reg primary_out,
  output reg aux_out,
  output reg chain_dout_out,
  output reg irq_out
);
  reg [7:0] shift_state_reg_ff;
  reg [7:0] polynomial_reg_ff;
  reg [7:0] seed_compare_reg_ff;
  reg [`CRC_SEQUENCE_FUNCTION_CTRL_W-1:0] control_reg_zero_ff;
  reg [7:0] nxt_shift;
  reg data_s1_ff, data_s2_ff, data_d_ff;
  reg clk_s1_ff, clk_s2_ff, clk_d_ff;
  reg chain_s1_ff, chain_s2_ff;
  reg cmp_d_ff;
  wire [7:0] stage_next;
  wire [7:0] msb_sel;
  wire stage_msb;
  wire enabled;
  wire pass_mode;
  wire step;
  wire serial_din;
  wire wr_en;
  wire cmp_now;
  wire data_rise;

  // Address match, used by the write decode; read decode uses a case
  function reg_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  assign enabled = control_reg_zero_ff[`CRC_SEQUENCE_FUNCTION_CTRL_ENABLE];
  assign pass_mode = control_reg_zero_ff[`CRC_SEQUENCE_FUNCTION_CTRL_PASS];
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign wr_en = psel_in & penable_in & pwrite_in;

  // Two-flop synchronisers for outside inputs
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      data_s1_ff <= 1'b0;
      data_s2_ff <= 1'b0;
      data_d_ff <= 1'b0;
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_d_ff <= 1'b0;
      chain_s1_ff <= 1'b0;
      chain_s2_ff <= 1'b0;
    end else begin
      data_s1_ff <= data_in;
      data_s2_ff <= data_s1_ff;
      data_d_ff <= data_s2_ff;
      clk_s1_ff <= blk_clk_in;
      clk_s2_ff <= clk_s1_ff;
      clk_d_ff <= clk_s2_ff;
      chain_s1_ff <= chain_din_in;
      chain_s2_ff <= chain_s1_ff;
    end
  end

  // Block clock edge steps the shift register
  assign step = clk_s2_ff & ~clk_d_ff;
  assign data_rise = data_s2_ff & ~data_d_ff;

  // chained block takes previous shift output
  assign serial_din = control_reg_zero_ff[`CRC_SEQUENCE_FUNCTION_CTRL_CHAIN] ? chain_s2_ff : data_s2_ff;

  crc_sequence_function_lfsr_stage u_stage (
    .state_in(shift_state_reg_ff),
    .poly_in(polynomial_reg_ff),
    .data_in(serial_din),
    .next_out(stage_next),
    .msb_sel_out(msb_sel),
    .msb_out(stage_msb)
  );

  // equal by default; mode bits select ordering
  assign cmp_now = !control_reg_zero_ff[`CRC_SEQUENCE_FUNCTION_CTRL_MODE0] ?
                   (shift_state_reg_ff == seed_compare_reg_ff) :
                   (control_reg_zero_ff[`CRC_SEQUENCE_FUNCTION_CTRL_MODE1] ?
                    (shift_state_reg_ff < seed_compare_reg_ff) :
                    (shift_state_reg_ff <= seed_compare_reg_ff));

  always @* begin
    nxt_shift = shift_state_reg_ff;
    if (!enabled && wr_en && reg_hit(paddr_in, `CRC_SEQUENCE_FUNCTION_OFF_SEED))
      nxt_shift = pwdata_in[7:0];
    else if (!enabled && wr_en && reg_hit(paddr_in, `CRC_SEQUENCE_FUNCTION_OFF_SHIFT))
      nxt_shift = pwdata_in[7:0];
    // shift each block clock; zero stays zero on zero data
    else if (enabled && !pass_mode && step)
      nxt_shift = stage_next;
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      shift_state_reg_ff <= `CRC_SEQUENCE_FUNCTION_RST_BYTE;
      polynomial_reg_ff <= `CRC_SEQUENCE_FUNCTION_RST_BYTE;
      seed_compare_reg_ff <= `CRC_SEQUENCE_FUNCTION_RST_BYTE;
      control_reg_zero_ff <= `CRC_SEQUENCE_FUNCTION_RST_CTRL;
    end else begin
      shift_state_reg_ff <= nxt_shift;
      if (wr_en && reg_hit(paddr_in, `CRC_SEQUENCE_FUNCTION_OFF_POLY))
        polynomial_reg_ff <= pwdata_in[7:0];
      if (wr_en && reg_hit(paddr_in, `CRC_SEQUENCE_FUNCTION_OFF_SEED))
        seed_compare_reg_ff <= pwdata_in[7:0];
      if (wr_en && reg_hit(paddr_in, `CRC_SEQUENCE_FUNCTION_OFF_CTRL))
        control_reg_zero_ff <= pwdata_in[`CRC_SEQUENCE_FUNCTION_CTRL_W-1:0];
    end
  end

  // Outputs registered from state; in pass mode primary, aux and irq come from synchronised inputs
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      primary_out <= 1'b0;
      aux_out <= 1'b0;
      chain_dout_out <= 1'b0;
      irq_out <= 1'b0;
      cmp_d_ff <= 1'b0;
    end else begin
      cmp_d_ff <= cmp_now;
      chain_dout_out <= stage_msb;
      if (pass_mode) begin
        primary_out <= data_s2_ff;
        aux_out <= clk_s2_ff;
        irq_out <= data_rise;
      end else begin
        primary_out <= stage_msb;
        aux_out <= enabled & cmp_now;
        irq_out <= enabled & cmp_now;
      end
    end
  end

  always @* begin
    prdata_out = `CRC_SEQUENCE_FUNCTION_ZERO32;
    if (psel_in && !pwrite_in) begin
      case (paddr_in)
        `CRC_SEQUENCE_FUNCTION_OFF_SHIFT: prdata_out[7:0] = shift_state_reg_ff;
        `CRC_SEQUENCE_FUNCTION_OFF_POLY: prdata_out[7:0] = polynomial_reg_ff;
        `CRC_SEQUENCE_FUNCTION_OFF_SEED: prdata_out[7:0] = seed_compare_reg_ff;
        `CRC_SEQUENCE_FUNCTION_OFF_CTRL: prdata_out[`CRC_SEQUENCE_FUNCTION_CTRL_W-1:0] = control_reg_zero_ff;
        `CRC_SEQUENCE_FUNCTION_OFF_STATUS: begin
          prdata_out[`CRC_SEQUENCE_FUNCTION_ST_CMP] = cmp_now;
          prdata_out[`CRC_SEQUENCE_FUNCTION_ST_IRQ] = irq_out;
          prdata_out[`CRC_SEQUENCE_FUNCTION_ST_PRIM] = primary_out;
          prdata_out[`CRC_SEQUENCE_FUNCTION_ST_AUX] = aux_out;
        end
        default: prdata_out = `CRC_SEQUENCE_FUNCTION_ZERO32;
      endcase
    end
  end

endmodule // crc_sequence_function_block

/* sim/crc_sequence_function_block_properties.sv */
/* Port checker for crc_sequence_function_block; assumes it is bound to that block and sees its ports only. */
`timescale 1ns/1ns
module crc_sequence_function_block_properties (
  input wire clock_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire data_in,
  input wire blk_clk_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire primary_out,
  input wire aux_out,
  input wire chain_dout_out,
  input wire irq_out
);
  wire wr = psel_in & penable_in & pwrite_in;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  ready_always_a: assert property (pready_out) else $error("no ready");
  no_slverr_a: assert property (!pslverr_out) else $error("slave error");
  upper_zero_a: assert property (
    psel_in && !pwrite_in |-> prdata_out[31:8] == 24'h0) else $error("upper bits");
  unmapped_zero_a: assert property (psel_in && !pwrite_in && paddr_in > 12'h010
    |-> prdata_out == 32'h0) else $error("unmapped read");
  state_hold_a: assert property ((!$rose(blk_clk_in) && !wr) [*7]
    |-> $stable(chain_dout_out)) else $error("state moved");
  prim_hold_a: assert property ((!$rose(blk_clk_in) && $stable(data_in) && !wr) [*7]
    |-> $stable(primary_out)) else $error("primary moved");
  irq_level_a: assert property (
    irq_out && $past(irq_out) |-> aux_out) else $error("irq without compare");
  pass_pulse_a: assert property (
    $rose(irq_out) && !aux_out |-> primary_out) else $error("pulse without data");
endmodule // crc_sequence_function_block_properties
bind crc_sequence_function_block crc_sequence_function_block_properties chk_i (.clock_in(clock_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .data_in(data_in), .blk_clk_in(blk_clk_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .primary_out(primary_out),
  .aux_out(aux_out), .chain_dout_out(chain_dout_out), .irq_out(irq_out));

/* sim/crc_sequence_function_far_end.sv */
/* Neighbouring block model driving data and block clock; assumes the bench clock. */
`timescale 1ns/1ns
module crc_sequence_function_far_end (
  input wire clock_in,
  output reg blk_clk_out = 1'h0,
  output reg data_out = 1'h0
);
  task step(input d);
    begin
      @(posedge clock_in);
      data_out <= d;
      repeat (3) @(posedge clock_in);
      blk_clk_out <= 1'h1;
      repeat (6) @(posedge clock_in);
      blk_clk_out <= 1'h0;
      repeat (6) @(posedge clock_in);
    end
  endtask
endmodule // crc_sequence_function_far_end

/* sim/test_crc_prs_lfsr_block.sv */
/* Bench for crc_sequence_function_block over APB; assumes crc_sequence_function_far_end drives data and block clock. */
`timescale 1ns/1ns
`include "crc_sequence_function_consts.vh"
module test_crc_prs_lfsr_block;
  reg clock_in = 1'h0;
  reg rst_in = 1'h1;
  reg psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  reg [11:0] addr = 12'h0;
  reg [31:0] wdata = 32'h0;
  reg [7:0] s, seed, poly;
  reg [1:0] mode = 2'h0;
  integer err_count = 0, cmp_count = 0, i;
  wire [31:0] rdata;
  wire ready, prim, aux, irq, bclk, dat;
  always #4 clock_in = ~clock_in;
  crc_sequence_function_far_end far (.clock_in(clock_in), .blk_clk_out(bclk), .data_out(dat));
  crc_sequence_function_block uut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata), .prdata_out(rdata),
    .pready_out(ready), .pslverr_out(), .data_in(dat), .blk_clk_in(bclk), .chain_din_in(dat),
    .primary_out(prim), .aux_out(aux), .chain_dout_out(), .irq_out(irq));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [11:0] a, input [7:0] d, input [31:0] e);
    begin
      @(posedge clock_in);
      {psel, pwr, addr, wdata} <= {1'h1, w, a, 24'h0, d};
      @(posedge clock_in);
      pen <= 1'h1;
      @(posedge clock_in);
      while (ready !== 1'h1) @(posedge clock_in);
      if (!w) chk(rdata, e);
      {psel, pen} <= 2'h0;
    end
  endtask
  function cmp_of(input [7:0] v);
    cmp_of = !mode[0] ? v == seed : (mode[1] ? v < seed : v <= seed);
  endfunction
  task step(input d);
    begin
      far.step(d);
      s = {s[6:0], s[7] ^ d} ^ ({poly[6:0], 1'h0} & {8{s[7] ^ d}});
      xfer(1'h0, `CRC_SEQUENCE_FUNCTION_OFF_SHIFT, 8'h0, s);
      xfer(1'h0, `CRC_SEQUENCE_FUNCTION_OFF_STATUS, 8'h0, {cmp_of(s), s[7], cmp_of(s), cmp_of(s)});
    end
  endtask
  task give_verdict;
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    err_count = err_count + 1;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 1'h0;
    for (i = 0; i < 9; i = i + 1) xfer(1'h0, {i[9:0], 2'h0}, 8'h0, {31'h0, i == 4});
    poly = 8'h8d;
    seed = 8'hff;
    s = seed;
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_POLY, poly, 32'h0);
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_SEED, seed, 32'h0);
    xfer(1'h0, `CRC_SEQUENCE_FUNCTION_OFF_SHIFT, 8'h0, {24'h0, s});
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_CTRL, 8'h01, 32'h0);
    xfer(1'h0, `CRC_SEQUENCE_FUNCTION_OFF_STATUS, 8'h0, 32'hf);
    for (i = 0; i < 40; i = i + 1) step(i % 3 == 1 && i < 20);
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_SHIFT, 8'h00, 32'h0);
    xfer(1'h0, `CRC_SEQUENCE_FUNCTION_OFF_SHIFT, 8'h0, {24'h0, s});
    seed = 8'h80;
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_SEED, seed, 32'h0);
    for (i = 0; i < 16; i = i + 1) begin
      mode = {i[3], 1'h1};
      xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_CTRL, {4'h0, mode, 2'h1}, 32'h0);
      step(1'h0);
    end
    mode = 2'h0;
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_CTRL, 8'h01, 32'h0);
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_CTRL, 8'h00, 32'h0);
    s = 8'h00;
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_SHIFT, s, 32'h0);
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_CTRL, 8'h01, 32'h0);
    for (i = 0; i < 3; i = i + 1) step(1'h0);
    xfer(1'h1, `CRC_SEQUENCE_FUNCTION_OFF_CTRL, 8'h03, 32'h0);
    fork
      far.step(1'h1);
      begin
        repeat (5) @(posedge clock_in);
        chk(irq, 1'h1);
      end
      begin
        repeat (10) @(posedge clock_in);
        chk(aux, 1'h1);
      end
    join
    chk(prim, 1'h1);
    give_verdict;
  end
endmodule // test_crc_prs_lfsr_block
